//--- verilog/fail_safe_mode_controller.sv
// Fail-safe operating mode state machine with Avalon-MM registers
`timescale 1ns/1ps
`default_nettype none
`include "fsc_map.svh"
module fail_safe_mode_controller #(
  parameter int TW = 24,
  parameter int RST_SHORT_CYC = `RST_SHORT_US * `CLK_MHZ,
  parameter int RST_LONG_CYC = `RST_LONG_US * `CLK_MHZ,
  parameter int WD_INIT_CYC = `WD_INIT_US * `CLK_MHZ,
  parameter int WD_PERIOD_CYC = `WD_PERIOD_US * `CLK_MHZ,
  parameter int INT_LIMIT_CYC = `INT_LIMIT_US * `CLK_MHZ,
  parameter int RESTART_DELAY_CYC = `RESTART_DELAY_US * `CLK_MHZ,
  parameter int CYC_PERIOD_CYC = `CYC_PERIOD_US * `CLK_MHZ,
  parameter int CYC_ON_CYC = `CYC_ON_US * `CLK_MHZ
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Events
  input wire fsc_pkg::wake_t wake_in,
  input wire logic osc_ok_in,
  input wire logic severe_fault_in,
  input wire logic host_supply_ok_in,
  input wire logic ext_reset_req_in,
  input wire logic int_raise_in,
  // Host and system outputs
  output logic host_reset_out_low,
  output logic host_supply_en_out,
  output logic can_active_out,
  output logic enable_out,
  output logic inhibit_limp_output_out,
  output logic inhibit_limp_output_oe_out,
  output logic switched_battery_output_out,
  output fsc_pkg::mode_state_t mode_state_out
);

  // ************************************************
  // Declarations
  // ************************************************
  fsc_pkg::mode_state_t state_q;
  fsc_pkg::mode_state_t state_d;
  fsc_pkg::cause_t cause_q;
  fsc_pkg::cause_t rst_cause;
  fsc_pkg::cfg_t cfg_q;
  logic rst_evt;
  logic wait_q;
  logic wr_take;
  logic rd_take;
  logic mode_wr;
  logic [2:0] mode_code;
  logic wd_trig;
  logic [TW-1:0] tmr_q;
  logic [TW-1:0] tmr_lim;
  logic tmr_done;
  logic [TW-1:0] wd_q;
  logic wd_fail;
  logic [TW-1:0] int_cnt_q;
  logic int_busy_q;
  logic int_expired;
  logic long_q;
  logic flash_armed_q;
  logic [1:0] seq_q;
  logic seq_done;
  logic [TW-1:0] cyc_q;
  logic smp_q;
  logic smp_prev_q;
  logic local_evt;
  logic wake_any;
  logic in_reset_states;

  // ************************************************
  // Avalon-MM slave
  // ************************************************
  assign wr_take = avs_write_in & ~wait_q;
  assign rd_take = avs_read_in & ~wait_q;
  assign mode_wr = wr_take & (avs_address_in == `ADDR_MODE);
  assign mode_code = avs_writedata_in[2:0];
  assign wd_trig = wr_take & (avs_address_in == `ADDR_WD_TRIG);

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wait_q <= 1'b1;
    end else if (!wait_q) begin
      wait_q <= 1'b1;
    end else if (avs_read_in | avs_write_in) begin
      wait_q <= 1'b0;
    end
  end

  assign avs_waitrequest_out = wait_q;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (wait_q & avs_read_in) begin
      case (avs_address_in)
        `ADDR_CONFIG: avs_readdata_out <= {24'h00_0000, cfg_q};
        `ADDR_STATUS: avs_readdata_out <= {22'h0, int_busy_q, flash_armed_q, cause_q, state_q};
        default: avs_readdata_out <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cfg_q <= `CFG_RESET;
    end else if (wr_take & (avs_address_in == `ADDR_CONFIG)) begin
      cfg_q <= avs_writedata_in[7:0];
    end else if (rst_evt | (state_d == fsc_pkg::ST_NORMAL && state_q != fsc_pkg::ST_NORMAL)) begin
      cfg_q.can_medium_control <= 1'b0;
    end
  end

  // ************************************************
  // Local event sampling and switched battery
  // ************************************************
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cyc_q <= '0;
    end else if (cyc_q == TW'(CYC_PERIOD_CYC - 1)) begin
      cyc_q <= '0;
    end else begin
      cyc_q <= cyc_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      smp_q <= 1'b1;
      smp_prev_q <= 1'b1;
    end else if (!cfg_q.local_cyclic || cyc_q == TW'(CYC_ON_CYC - 1)) begin
      smp_q <= wake_in.loc_level;
      smp_prev_q <= smp_q;
    end
  end

  assign local_evt = smp_prev_q & ~smp_q;
  assign wake_any = wake_in.can | wake_in.lin | local_evt;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      switched_battery_output_out <= 1'b0;
    end else begin
      switched_battery_output_out <= cfg_q.v3_on & (~cfg_q.v3_cyclic | (cyc_q < TW'(CYC_ON_CYC)));
    end
  end

  // ************************************************
  // Mode timer
  // ************************************************
  always_comb begin
    case (state_q)
      fsc_pkg::ST_STARTUP_RST: tmr_lim = (long_q | cfg_q.rls) ? TW'(RST_LONG_CYC) : TW'(RST_SHORT_CYC);
      fsc_pkg::ST_RESTART_RST: tmr_lim = TW'(RST_LONG_CYC);
      fsc_pkg::ST_STARTUP_WAIT: tmr_lim = TW'(WD_INIT_CYC);
      fsc_pkg::ST_RESTART_WAIT: tmr_lim = TW'(WD_INIT_CYC);
      fsc_pkg::ST_FS_DELAY: tmr_lim = TW'(RESTART_DELAY_CYC);
      fsc_pkg::ST_FLASH: tmr_lim = TW'(WD_PERIOD_CYC);
      default: tmr_lim = '1;
    endcase
  end

  assign tmr_done = (tmr_q == tmr_lim - 1'b1);

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tmr_q <= '0;
    end else if (state_d != state_q || (state_q == fsc_pkg::ST_FLASH && mode_wr)) begin
      tmr_q <= '0;
    end else if (!tmr_done) begin
      tmr_q <= tmr_q + 1'b1;
    end
  end

  // ************************************************
  // Window watchdog and interrupt monitor
  // ************************************************
  assign wd_fail = (wd_trig & (wd_q < TW'(WD_PERIOD_CYC / 2))) | (wd_q == TW'(WD_PERIOD_CYC - 1));

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wd_q <= '0;
    end else if (state_q != fsc_pkg::ST_NORMAL || wd_trig) begin
      wd_q <= '0;
    end else begin
      wd_q <= wd_q + 1'b1;
    end
  end

  assign int_expired = int_busy_q & (int_cnt_q == TW'(INT_LIMIT_CYC - 1));

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      int_busy_q <= 1'b0;
    end else if (state_q != fsc_pkg::ST_NORMAL) begin
      int_busy_q <= 1'b0;
    end else if (int_raise_in) begin
      int_busy_q <= 1'b1;
    end else if (rd_take & (avs_address_in == `ADDR_INT_ACK)) begin
      int_busy_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      int_cnt_q <= '0;
    end else if (!int_busy_q || int_expired) begin
      int_cnt_q <= '0;
    end else begin
      int_cnt_q <= int_cnt_q + 1'b1;
    end
  end

  // ************************************************
  // Flash entry sequence
  // ************************************************
  assign seq_done = mode_wr & (seq_q == 2'h2) & (mode_code == `CODE_SEQ_A);

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      seq_q <= 2'h0;
    end else if (state_q != fsc_pkg::ST_NORMAL || seq_done) begin
      seq_q <= 2'h0;
    end else if (mode_wr) begin
      if (mode_code == `CODE_SEQ_A) begin
        seq_q <= 2'h1;
      end else if (mode_code == `CODE_SEQ_B && seq_q == 2'h1) begin
        seq_q <= 2'h2;
      end else begin
        seq_q <= 2'h0;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flash_armed_q <= 1'b0;
    end else if (rst_evt) begin
      flash_armed_q <= (rst_cause == fsc_pkg::CAUSE_FLASH_ENTRY);
    end else if (state_q == fsc_pkg::ST_STARTUP_WAIT && state_d != state_q) begin
      flash_armed_q <= 1'b0;
    end
  end

  // ************************************************
  // Mode state machine
  // ************************************************
  always_comb begin
    state_d = state_q;
    rst_evt = 1'b0;
    rst_cause = fsc_pkg::CAUSE_POWER_ON;
    if (!osc_ok_in || severe_fault_in) begin
      state_d = fsc_pkg::ST_FAILSAFE;
    end else if (ext_reset_req_in && state_q != fsc_pkg::ST_FAILSAFE && state_q != fsc_pkg::ST_FS_DELAY) begin
      rst_evt = 1'b1;
      rst_cause = fsc_pkg::CAUSE_EXTERNAL;
    end else begin
      case (state_q)
        fsc_pkg::ST_STARTUP_RST: begin
          if (tmr_done) begin
            state_d = fsc_pkg::ST_STARTUP_WAIT;
          end
        end
        fsc_pkg::ST_STARTUP_WAIT: begin
          if (mode_wr && mode_code == `CODE_NORMAL) begin
            state_d = fsc_pkg::ST_NORMAL;
          end else if (mode_wr && mode_code == `CODE_FLASH && flash_armed_q) begin
            state_d = fsc_pkg::ST_FLASH;
          end else if (mode_wr || tmr_done) begin
            state_d = fsc_pkg::ST_RESTART_RST;
          end
        end
        fsc_pkg::ST_RESTART_RST: begin
          if (tmr_done) begin
            state_d = host_supply_ok_in ? fsc_pkg::ST_RESTART_WAIT : fsc_pkg::ST_FAILSAFE;
          end
        end
        fsc_pkg::ST_RESTART_WAIT: begin
          if (mode_wr && mode_code == `CODE_NORMAL) begin
            state_d = fsc_pkg::ST_NORMAL;
          end else if (mode_wr || tmr_done || !host_supply_ok_in) begin
            state_d = fsc_pkg::ST_FAILSAFE;
          end
        end
        fsc_pkg::ST_NORMAL: begin
          if (wd_fail) begin
            rst_evt = 1'b1;
            rst_cause = fsc_pkg::CAUSE_WATCHDOG;
          end else if (int_expired) begin
            rst_evt = 1'b1;
            rst_cause = fsc_pkg::CAUSE_INT_TIMEOUT;
          end else if (seq_done) begin
            rst_evt = 1'b1;
            rst_cause = fsc_pkg::CAUSE_FLASH_ENTRY;
          end else if (mode_wr && mode_code == `CODE_STANDBY) begin
            state_d = fsc_pkg::ST_STANDBY;
          end
        end
        fsc_pkg::ST_STANDBY: begin
          if (wake_any) begin
            rst_evt = 1'b1;
            rst_cause = fsc_pkg::CAUSE_WAKE;
          end
        end
        fsc_pkg::ST_FLASH: begin
          if (mode_wr && mode_code == `CODE_FLASH_LEAVE) begin
            rst_evt = 1'b1;
            rst_cause = fsc_pkg::CAUSE_FLASH_EXIT;
          end else if (mode_wr && mode_code != `CODE_FLASH_SERVE) begin
            rst_evt = 1'b1;
            rst_cause = fsc_pkg::CAUSE_ILLEGAL_MODE;
          end else if (!mode_wr && tmr_done) begin
            rst_evt = 1'b1;
            rst_cause = fsc_pkg::CAUSE_WATCHDOG;
          end
        end
        fsc_pkg::ST_FAILSAFE: begin
          if (wake_any) begin
            state_d = fsc_pkg::ST_FS_DELAY;
          end
        end
        fsc_pkg::ST_FS_DELAY: begin
          if (tmr_done) begin
            rst_evt = 1'b1;
            rst_cause = fsc_pkg::CAUSE_WAKE;
          end
        end
        default: begin
          rst_evt = 1'b1;
        end
      endcase
    end
    if (rst_evt) begin
      state_d = fsc_pkg::ST_STARTUP_RST;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= fsc_pkg::ST_STARTUP_RST;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cause_q <= fsc_pkg::CAUSE_POWER_ON;
    end else if (rst_evt) begin
      cause_q <= rst_cause;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      long_q <= 1'b0;
    end else if (state_d == fsc_pkg::ST_RESTART_RST || state_d == fsc_pkg::ST_FS_DELAY) begin
      long_q <= 1'b1;
    end else if (state_d == fsc_pkg::ST_NORMAL) begin
      long_q <= 1'b0;
    end
  end

  // ************************************************
  // Outputs
  // ************************************************
  assign in_reset_states = (state_d == fsc_pkg::ST_STARTUP_RST) || (state_d == fsc_pkg::ST_RESTART_RST) ||
                           (state_d == fsc_pkg::ST_FAILSAFE) || (state_d == fsc_pkg::ST_FS_DELAY);

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      host_reset_out_low <= 1'b0;
      host_supply_en_out <= 1'b1;
      can_active_out <= 1'b0;
      enable_out <= 1'b0;
      inhibit_limp_output_out <= 1'b0;
      inhibit_limp_output_oe_out <= 1'b0;
      mode_state_out <= fsc_pkg::ST_STARTUP_RST;
    end else begin
      host_reset_out_low <= ~in_reset_states;
      host_supply_en_out <= (state_d != fsc_pkg::ST_FAILSAFE) && (state_d != fsc_pkg::ST_FS_DELAY);
      can_active_out <= (state_d == fsc_pkg::ST_NORMAL) & (state_q == fsc_pkg::ST_NORMAL) & cfg_q.can_medium_control;
      enable_out <= (state_d == fsc_pkg::ST_NORMAL) & cfg_q.en_bit;
      inhibit_limp_output_out <= cfg_q.inh_level;
      inhibit_limp_output_oe_out <= (state_d == fsc_pkg::ST_NORMAL) & cfg_q.inh_drive;
      mode_state_out <= state_d;
    end
  end

  // ************************************************
  // Assertions
  // ************************************************
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence s_fs_wake;
    state_q == fsc_pkg::ST_FAILSAFE && wake_any && osc_ok_in && !severe_fault_in;
  endsequence

  sequence s_delay_end;
    state_q == fsc_pkg::ST_FS_DELAY && tmr_done && osc_ok_in && !severe_fault_in && !ext_reset_req_in;
  endsequence

  property p_rst_low;
    (state_q == fsc_pkg::ST_STARTUP_RST) |-> !host_reset_out_low;
  endproperty
  a_rst_low: assert property (p_rst_low) else $error("host reset high during start-up reset");

  property p_osc_fail;
    !osc_ok_in |=> (state_q == fsc_pkg::ST_FAILSAFE) && !host_supply_en_out;
  endproperty
  a_osc_fail: assert property (p_osc_fail) else $error("oscillator failure did not force fail-safe");

  property p_fs_hold;
    (state_q == fsc_pkg::ST_FAILSAFE && !wake_any) |=> (state_q == fsc_pkg::ST_FAILSAFE);
  endproperty
  a_fs_hold: assert property (p_fs_hold) else $error("fail-safe left without wake-up");

  property p_fs_exit;
    s_fs_wake |=> (state_q == fsc_pkg::ST_FS_DELAY) ##0 long_q;
  endproperty
  a_fs_exit: assert property (p_fs_exit) else $error("wake-up did not start restart delay");

  property p_delay_end;
    s_delay_end |=> (state_q == fsc_pkg::ST_STARTUP_RST) ##1 !host_reset_out_low;
  endproperty
  a_delay_end: assert property (p_delay_end) else $error("restart delay did not lead to start-up");

  property p_restart_long;
    (state_q == fsc_pkg::ST_RESTART_RST) |-> long_q && (tmr_lim == TW'(RST_LONG_CYC));
  endproperty
  a_restart_long: assert property (p_restart_long) else $error("restart without long reset");

  property p_can_off;
    $rose(state_q == fsc_pkg::ST_NORMAL) |-> !can_active_out ##1 !can_active_out;
  endproperty
  a_can_off: assert property (p_can_off) else $error("CAN active on normal entry");

  property p_inh_float;
    !cfg_q.inh_drive |=> !inhibit_limp_output_oe_out;
  endproperty
  a_inh_float: assert property (p_inh_float) else $error("inhibit output driven without command");

  property p_int_timeout;
    (state_q == fsc_pkg::ST_NORMAL && int_expired && osc_ok_in && !severe_fault_in && !ext_reset_req_in && !wd_fail)
      |=> (state_q == fsc_pkg::ST_STARTUP_RST) && (cause_q == fsc_pkg::CAUSE_INT_TIMEOUT);
  endproperty
  a_int_timeout: assert property (p_int_timeout) else $error("interrupt timeout did not reset");

  property p_wd_early;
    (state_q == fsc_pkg::ST_NORMAL && wd_trig && wd_q < TW'(WD_PERIOD_CYC / 2) && osc_ok_in && !severe_fault_in
      && !ext_reset_req_in) |=> (cause_q == fsc_pkg::CAUSE_WATCHDOG) && (state_q == fsc_pkg::ST_STARTUP_RST);
  endproperty
  a_wd_early: assert property (p_wd_early) else $error("early watchdog service not punished");

  property p_cause;
    rst_evt |=> (cause_q == $past(rst_cause)) && (state_q == fsc_pkg::ST_STARTUP_RST);
  endproperty
  a_cause: assert property (p_cause) else $error("reset cause not recorded");

endmodule
`default_nettype wire

//--- include/fsc_map.svh
// Constants of the fail-safe mode controller
`ifndef FSC_MAP_SVH
`define FSC_MAP_SVH
`define ADDR_MODE 5'h00
`define ADDR_CONFIG 5'h04
`define ADDR_WD_TRIG 5'h08
`define ADDR_STATUS 5'h0C
`define ADDR_INT_ACK 5'h10
`define CFG_RESET 8'h00
`define CODE_NORMAL 3'h5
`define CODE_FLASH 3'h3
`define CODE_STANDBY 3'h4
`define CODE_SEQ_A 3'h7
`define CODE_SEQ_B 3'h1
`define CODE_FLASH_SERVE 3'h7
`define CODE_FLASH_LEAVE 3'h6
`define CLK_MHZ 20
`define RST_SHORT_US 1000
`define RST_LONG_US 20000
`define WD_INIT_US 64000
`define WD_PERIOD_US 32000
`define INT_LIMIT_US 2000
`define RESTART_DELAY_US 10000
`define CYC_PERIOD_US 16000
`define CYC_ON_US 500
`endif

//--- include/fsc_pkg.sv
// Types of the fail-safe mode controller
package fsc_pkg;
  typedef enum logic [3:0] {
    ST_STARTUP_RST = 4'h0,
    ST_STARTUP_WAIT = 4'h1,
    ST_RESTART_RST = 4'h3,
    ST_RESTART_WAIT = 4'h2,
    ST_NORMAL = 4'h6,
    ST_STANDBY = 4'h7,
    ST_FLASH = 4'h5,
    ST_FAILSAFE = 4'h4,
    ST_FS_DELAY = 4'hC
  } mode_state_t;
  typedef enum logic [3:0] {
    CAUSE_POWER_ON = 4'h0,
    CAUSE_WAKE = 4'h1,
    CAUSE_WATCHDOG = 4'h2,
    CAUSE_INT_TIMEOUT = 4'h3,
    CAUSE_EXTERNAL = 4'h4,
    CAUSE_FLASH_ENTRY = 4'h6,
    CAUSE_FLASH_EXIT = 4'h7,
    CAUSE_ILLEGAL_MODE = 4'h8
  } cause_t;
  typedef struct packed {
    logic v3_on;
    logic v3_cyclic;
    logic local_cyclic;
    logic inh_level;
    logic inh_drive;
    logic en_bit;
    logic can_medium_control;
    logic rls;
  } cfg_t;
  typedef struct packed {
    logic can;
    logic lin;
    logic loc_level;
  } wake_t;
endpackage

//--- tb/host_model.sv
// Host microcontroller model driving the Avalon bus
`timescale 1ns/1ps
`default_nettype none
`include "fsc_map.svh"
module host_model (
  // Clock and answer
  input wire logic clk_sys_in,
  input wire logic [31:0] rdata_in,
  input wire logic wait_in,
  // Request
  output logic [4:0] addr_out,
  output logic rd_out,
  output logic wr_out,
  output logic [31:0] wdata_out
);
  logic stuck = 1'h0;
  logic [31:0] q;
  initial begin
    addr_out = 5'h00;
    rd_out = 1'h0;
    wr_out = 1'h0;
    wdata_out = 32'h0000_0000;
  end
  // Request held until waitrequest seen low, or for at most 20 cycles before stuck is set
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    addr_out <= a;
    wdata_out <= d;
    rd_out <= ~w;
    wr_out <= w;
    @(posedge clk_sys_in);
    while (wait_in !== 1'h0 && n < 20) begin
      @(posedge clk_sys_in);
      n++;
    end
    stuck = stuck | (n == 20);
    r = rdata_in;
    rd_out <= 1'h0;
    wr_out <= 1'h0;
    @(posedge clk_sys_in);
  endtask
  task automatic mode(input logic [2:0] c);
    acc(1'h1, `ADDR_MODE, {29'h0, c}, q);
  endtask
  task automatic serve();
    acc(1'h1, `ADDR_WD_TRIG, 32'h0000_0000, q);
  endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench of the fail-safe mode controller
`timescale 1ns/1ps
`default_nettype none
`include "fsc_map.svh"
module testbench;
  localparam int RS = 20;
  localparam int RL = 40;
  localparam int RD = 30;
  logic clk_sys_in = 1'h0;
  logic reset_n_in = 1'h0;
  logic osc_ok = 1'h1;
  logic fault = 1'h0;
  logic sup_ok = 1'h1;
  logic ext_rst = 1'h0;
  logic int_raise = 1'h0;
  fsc_pkg::wake_t wake = 3'h1;
  fsc_pkg::mode_state_t st;
  logic [4:0] addr;
  logic rd, wr, waitreq, rst_low, sup_en, can_act, en, inh, inh_oe, v3;
  logic [31:0] wdata, rdata, q;
  int n_errors = 0;
  int checked = 0;
  always #25 clk_sys_in = ~clk_sys_in;
  fail_safe_mode_controller #(.RST_SHORT_CYC(RS), .RST_LONG_CYC(RL), .WD_INIT_CYC(100), .WD_PERIOD_CYC(64),
    .INT_LIMIT_CYC(20), .RESTART_DELAY_CYC(RD), .CYC_PERIOD_CYC(32), .CYC_ON_CYC(4)) DUT (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .wake_in(wake), .osc_ok_in(osc_ok), .severe_fault_in(fault), .host_supply_ok_in(sup_ok),
    .ext_reset_req_in(ext_rst), .int_raise_in(int_raise), .host_reset_out_low(rst_low),
    .host_supply_en_out(sup_en), .can_active_out(can_act), .enable_out(en), .inhibit_limp_output_out(inh),
    .inhibit_limp_output_oe_out(inh_oe), .switched_battery_output_out(v3), .mode_state_out(st));
  host_model host (.clk_sys_in(clk_sys_in), .rdata_in(rdata), .wait_in(waitreq), .addr_out(addr),
    .rd_out(rd), .wr_out(wr), .wdata_out(wdata));
  always @(posedge clk_sys_in) begin
    if (host.stuck) begin
      n_errors++;
      stop_test();
    end
  end
  // ****************
  // Checks and waits
  // ****************
  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic chs(input fsc_pkg::mode_state_t e);
    checked++;
    if (st !== e) begin
      n_errors++;
      $display("BAD state expected %0h seen %0h", e, st);
    end
  endtask
  task automatic go(input fsc_pkg::mode_state_t s, input int lim, output int n);
    n = 0;
    while (st !== s && n < lim) begin
      @(posedge clk_sys_in);
      n++;
    end
    chs(s);
    if (st !== s) stop_test();
  endtask
  task automatic cause_is(input int e);
    host.acc(1'h0, `ADDR_STATUS, 32'h0000_0000, q);
    chk("cause", e, q[7:4]);
  endtask
  task automatic len(input string nm, input fsc_pkg::mode_state_t s, input int e);
    int n;
    go(s, e + 10, n);
    chk(nm, 1, n >= e - 2 && n <= e + 2);
  endtask
  // *********
  // Scenarios
  // *********
  task automatic t_power();
    chs(fsc_pkg::ST_STARTUP_RST);
    chk("reset", 0, rst_low);
    len("short", fsc_pkg::ST_STARTUP_WAIT, RS);
    chk("reset", 1, rst_low);
  endtask
  task automatic t_normal();
    int n;
    host.mode(`CODE_NORMAL);
    go(fsc_pkg::ST_NORMAL, 5, n);
    chk("can", 0, can_act);
    host.acc(1'h1, `ADDR_CONFIG, 32'h0000_0006, q);
    @(posedge clk_sys_in);
    chk("can", 1, can_act);
    chk("en", 1, en);
    repeat (34) @(posedge clk_sys_in);
    host.serve();
    repeat (40) @(posedge clk_sys_in);
    chs(fsc_pkg::ST_NORMAL);
    int_raise <= 1'h1;
    @(posedge clk_sys_in);
    int_raise <= 1'h0;
    go(fsc_pkg::ST_STARTUP_RST, 30, n);
    host.acc(1'h0, `ADDR_STATUS, 32'h0000_0000, q);
    chk("cause", 3, q[7:4]);
  endtask
  task automatic t_restart();
    int n;
    go(fsc_pkg::ST_RESTART_RST, 150, n);
    len("long", fsc_pkg::ST_RESTART_WAIT, RL);
    host.mode(`CODE_FLASH);
    go(fsc_pkg::ST_FAILSAFE, 5, n);
    chk("supply", 0, sup_en);
  endtask
  task automatic t_failsafe();
    int n;
    osc_ok <= 1'h0;
    wake.can <= 1'h1;
    repeat (5) @(posedge clk_sys_in);
    chs(fsc_pkg::ST_FAILSAFE);
    osc_ok <= 1'h1;
    wake.can <= 1'h0;
    repeat (3) @(posedge clk_sys_in);
    chs(fsc_pkg::ST_FAILSAFE);
    wake.lin <= 1'h1;
    go(fsc_pkg::ST_FS_DELAY, 5, n);
    wake.lin <= 1'h0;
    len("delay", fsc_pkg::ST_STARTUP_RST, RD);
    len("long", fsc_pkg::ST_STARTUP_WAIT, RL);
  endtask
  task automatic t_fault();
    int n;
    host.mode(`CODE_NORMAL);
    go(fsc_pkg::ST_NORMAL, 5, n);
    int_raise <= 1'h1;
    @(posedge clk_sys_in);
    int_raise <= 1'h0;
    host.acc(1'h0, `ADDR_INT_ACK, 32'h0000_0000, q);
    repeat (20) @(posedge clk_sys_in);
    chs(fsc_pkg::ST_NORMAL);
    host.serve();
    go(fsc_pkg::ST_STARTUP_RST, 5, n);
    cause_is(2);
    go(fsc_pkg::ST_STARTUP_WAIT, 30, n);
    host.mode(`CODE_NORMAL);
    host.mode(`CODE_SEQ_A);
    host.mode(`CODE_SEQ_B);
    host.mode(`CODE_SEQ_A);
    cause_is(6);
    go(fsc_pkg::ST_STARTUP_WAIT, 30, n);
    host.mode(`CODE_FLASH);
    go(fsc_pkg::ST_FLASH, 5, n);
    host.mode(`CODE_FLASH_LEAVE);
    cause_is(7);
    go(fsc_pkg::ST_STARTUP_WAIT, 30, n);
    ext_rst <= 1'h1;
    @(posedge clk_sys_in);
    ext_rst <= 1'h0;
    go(fsc_pkg::ST_STARTUP_RST, 5, n);
    cause_is(4);
    go(fsc_pkg::ST_STARTUP_WAIT, 30, n);
    host.mode(`CODE_NORMAL);
    go(fsc_pkg::ST_NORMAL, 5, n);
    fault <= 1'h1;
    go(fsc_pkg::ST_FAILSAFE, 5, n);
    fault <= 1'h0;
  endtask
  task automatic t_local();
    int n;
    int ones;
    ones = 0;
    host.acc(1'h1, `ADDR_CONFIG, 32'h0000_00F8, q);
    @(posedge clk_sys_in);
    chk("inh", 1, inh);
    chk("inh_oe", 0, inh_oe);
    repeat (32) begin
      @(posedge clk_sys_in);
      ones += v3;
    end
    chk("v3", 4, ones);
    wake.loc_level <= 1'h0;
    go(fsc_pkg::ST_FS_DELAY, 40, n);
    wake.loc_level <= 1'h1;
    len("delay", fsc_pkg::ST_STARTUP_RST, RD);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_in);
    reset_n_in <= 1'h1;
    t_power();
    t_normal();
    t_restart();
    t_failsafe();
    t_fault();
    t_local();
    chk("bus", 0, host.stuck);
    stop_test();
  end
endmodule
`default_nettype wire
